// ==== core/cmc_defs.svh ====
// constants for the CAN mode control and bit-timing block
// How it works
// - auto recovery after 128x11 recessive bits
// - manual recovery also needs change request cleared
// - loopback: own ack, no drive, frame looped
// - looped frame identifier never written
// - no receiver: store into first mailbox
// - receivers exist, no match: discard frame
// - soft reset bit write-only, reads zero
// - soft reset restores unprotected defaults
// - soft reset keeps mailboxes and error counters
// - soft reset cancels transmits at frame boundary
// - index field names mailbox for data change
// - index top bit reserved in compat mode
// - suspend now if idle, else after frame
// - transmitter suspends after ack or error frame
// - after error suspend, retransmit on resume
// - receiver suspends after ack or error frame
// - resume only when bus idle
// - suspended: no traffic, counters frozen
// - timing writes only in init with unlock
// - timing field layout, reset zero
// - data change request inhibits that mailbox
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH
`define CMC_ADDR_W 12
`define CMC_OFS_MODE 12'h000
`define CMC_OFS_TIMING 12'h004
`define CMC_B_INDEX_HI 4
`define CMC_B_SRST 5
`define CMC_B_LOOP 6
`define CMC_B_ABO 7
`define CMC_B_CDR 8
`define CMC_B_CCR 12
`define CMC_B_COMPAT 13
`define CMC_MODE_RESET 32'h0000_1000
`define CMC_TIMING_MASK 32'h00FF_03FF
`define CMC_TIMING_RESET 32'h0000_0000
`define CMC_RUN_BITS 4'hA
`define CMC_BOFF_GROUPS 8'h7F
`endif

// ==== core/cmc_pkg.sv ====
// types for the CAN mode control and bit-timing block
package cmc_pkg;
	typedef struct packed {
		logic [7:0] baud_prescale_value;
		logic [5:0] reserved_hi;
		logic [1:0] resync_jump_width;
		logic triple_sample_select;
		logic [3:0] first_time_segment;
		logic [2:0] second_time_segment;
	} cmc_timing_t;
	typedef struct packed {
		logic standard_compat_mode;
		logic config_change_request;
		logic data_change_request;
		logic auto_recover_enable;
		logic self_loopback_mode;
		logic [4:0] data_update_mailbox_index;
	} cmc_mode_t;
	typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_SUSP, ST_WAKE} cmc_susp_t;
endpackage : cmc_pkg

// ==== core/cmc_top.sv ====
// CAN mode control, suspend sequencing and bit-timing register with APB slave
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"
module cmc_top
	import cmc_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic PROTECTED_WRITE_UNLOCK,
	input wire logic BIT_TICK,
	input wire logic BIT_RECESSIVE,
	input wire logic BUS_OFF_ENTER,
	input wire logic BUS_IDLE,
	input wire logic FRAME_END,
	input wire logic FRAME_ERROR,
	input wire logic TX_ACTIVE,
	input wire logic TX_FRAME_DONE,
	input wire logic [31:0] RX_CAPABLE,
	input wire logic [31:0] ACCEPT_HIT,
	input wire logic SUSPEND_REQ,
	output logic BUS_OFF,
	output logic TX_DRIVE_EN,
	output logic SELF_ACK,
	output logic LOOP_STORE_VALID,
	output logic [4:0] LOOP_STORE_INDEX,
	output logic LOOP_ID_WRITE,
	output logic LOOP_DISCARD,
	output logic SOFT_RESET_PULSE,
	output logic TX_CANCEL,
	output logic [31:0] MAILBOX_TX_INHIBIT,
	output logic SUSPENDED,
	output logic ERR_CNT_FREEZE,
	output logic RETRANSMIT,
	output cmc_timing_t TIMING
);
	cmc_mode_t mode_reg;
	cmc_timing_t timing_reg;
	cmc_susp_t susp_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	logic srst_reg, cancel_reg;
	logic bus_off_reg, recovered_reg;
	logic [3:0] run_reg;
	logic [7:0] grp_reg;
	logic loop_valid_reg, loop_discard_reg;
	logic [4:0] loop_idx_reg;
	logic drain_err_reg, retx_pending_reg, retx_reg;
	logic [31:0] inhibit_reg;
	logic drive_reg, ack_reg;
	logic access, wr, rd, hit_mode, hit_timing;
	logic [31:0] mode_rd;
	logic susp_now;
	localparam logic [31:0] mode_rst = `CMC_MODE_RESET;

	function automatic logic [4:0] first_set(input logic [31:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = 31; i >= 0; i--)
		begin
			if (v[i])
				idx = 5'(i);
		end
		return idx;
	endfunction : first_set

	function automatic logic [31:0] pack_mode(input cmc_mode_t m);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[4:0] = m.data_update_mailbox_index;
		r[`CMC_B_LOOP] = m.self_loopback_mode;
		r[`CMC_B_ABO] = m.auto_recover_enable;
		r[`CMC_B_CDR] = m.data_change_request;
		r[`CMC_B_CCR] = m.config_change_request;
		r[`CMC_B_COMPAT] = m.standard_compat_mode;
		return r;
	endfunction : pack_mode

	// request is answered one cycle into the access phase
	assign access = PSEL && PENABLE && !pready_reg;
	assign hit_mode = (PADDR == `CMC_OFS_MODE);
	assign hit_timing = (PADDR == `CMC_OFS_TIMING);
	assign wr = access && PWRITE;
	assign rd = access && !PWRITE;
	assign mode_rd = pack_mode(mode_reg);
	// the wake state still counts as suspended: no drive until the bus has gone idle
	assign susp_now = (susp_reg == ST_SUSP) || (susp_reg == ST_WAKE);

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= access;
			pslverr_reg <= access && !hit_mode && !hit_timing;
			if (rd)
				prdata_reg <= hit_mode ? mode_rd : (hit_timing ? 32'(timing_reg) : 32'h0000_0000);
			else
				prdata_reg <= 32'h0000_0000;
		end
	end

	// soft reset bit is never stored, only pulsed
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			srst_reg <= 1'b0;
		else
			srst_reg <= wr && hit_mode && PWDATA[`CMC_B_SRST];
	end

	// protected bits only move with the unlock held; soft reset leaves them
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			mode_reg <= cmc_mode_t'({mode_rst[`CMC_B_COMPAT], mode_rst[`CMC_B_CCR],
				mode_rst[`CMC_B_CDR], mode_rst[`CMC_B_ABO], mode_rst[`CMC_B_LOOP],
				mode_rst[4:0]});
		else if (srst_reg)
		begin
			mode_reg.data_change_request <= 1'b0;
			mode_reg.data_update_mailbox_index <= 5'h00;
		end
		else if (wr && hit_mode)
		begin
			mode_reg.data_change_request <= PWDATA[`CMC_B_CDR];
			mode_reg.data_update_mailbox_index[3:0] <= PWDATA[3:0];
			mode_reg.data_update_mailbox_index[4] <= mode_reg.standard_compat_mode ? 1'b0 :
				PWDATA[`CMC_B_INDEX_HI];
			if (PROTECTED_WRITE_UNLOCK)
			begin
				mode_reg.auto_recover_enable <= PWDATA[`CMC_B_ABO];
				mode_reg.self_loopback_mode <= PWDATA[`CMC_B_LOOP];
				mode_reg.config_change_request <= PWDATA[`CMC_B_CCR];
				mode_reg.standard_compat_mode <= PWDATA[`CMC_B_COMPAT];
				if (PWDATA[`CMC_B_COMPAT])
					mode_reg.data_update_mailbox_index[4] <= 1'b0;
			end
		end
	end

	// init mode is the change request held; protected also from soft reset
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			timing_reg <= cmc_timing_t'(24'(`CMC_TIMING_RESET));
		else if (wr && hit_timing && PROTECTED_WRITE_UNLOCK && mode_reg.config_change_request)
			timing_reg <= cmc_timing_t'(24'(PWDATA & `CMC_TIMING_MASK));
	end

	// recovery counts runs of 11 recessive bits; a dominant bit restarts the run
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			bus_off_reg <= 1'b0;
			recovered_reg <= 1'b0;
			run_reg <= 4'h0;
			grp_reg <= 8'h00;
		end
		else if (BUS_OFF_ENTER)
		begin
			bus_off_reg <= 1'b1;
			recovered_reg <= 1'b0;
			run_reg <= 4'h0;
			grp_reg <= 8'h00;
		end
		else if (bus_off_reg)
		begin
			if (recovered_reg)
			begin
				if (mode_reg.auto_recover_enable || !mode_reg.config_change_request)
				begin
					bus_off_reg <= 1'b0;
					recovered_reg <= 1'b0;
				end
			end
			else if (BIT_TICK)
			begin
				if (!BIT_RECESSIVE)
					run_reg <= 4'h0;
				else if (run_reg == `CMC_RUN_BITS)
				begin
					run_reg <= 4'h0;
					grp_reg <= grp_reg + 8'h01;
					if (grp_reg == `CMC_BOFF_GROUPS)
						recovered_reg <= 1'b1;
				end
				else
					run_reg <= run_reg + 4'h1;
			end
		end
	end

	// loopback routing of each finished transmit
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			loop_valid_reg <= 1'b0;
			loop_discard_reg <= 1'b0;
			loop_idx_reg <= 5'h00;
			drive_reg <= 1'b0;
			ack_reg <= 1'b0;
		end
		else
		begin
			drive_reg <= !mode_reg.self_loopback_mode && !susp_now;
			ack_reg <= mode_reg.self_loopback_mode && !susp_now;
			loop_valid_reg <= 1'b0;
			loop_discard_reg <= 1'b0;
			if (TX_FRAME_DONE && mode_reg.self_loopback_mode)
			begin
				if (RX_CAPABLE == 32'h0000_0000)
				begin
					loop_valid_reg <= 1'b1;
					loop_idx_reg <= 5'h00;
				end
				else if ((RX_CAPABLE & ACCEPT_HIT) != 32'h0000_0000)
				begin
					loop_valid_reg <= 1'b1;
					loop_idx_reg <= first_set(RX_CAPABLE & ACCEPT_HIT);
				end
				else
					loop_discard_reg <= 1'b1;
			end
		end
	end

	// cancel is held until idle so no frame on the wire is cut short
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			cancel_reg <= 1'b0;
		else if (srst_reg)
			cancel_reg <= 1'b1;
		else if (BUS_IDLE)
			cancel_reg <= 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
			inhibit_reg <= 32'h0000_0000;
		else
			inhibit_reg <= mode_reg.data_change_request ?
				(32'h0000_0001 << mode_reg.data_update_mailbox_index) : 32'h0000_0000;
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
			susp_reg <= ST_RUN;
		else
		begin
			case (susp_reg)
			ST_RUN:
				if (SUSPEND_REQ)
					susp_reg <= BUS_IDLE ? ST_SUSP : ST_DRAIN;
			ST_DRAIN:
				if (FRAME_END)
					susp_reg <= ST_SUSP;
			ST_SUSP:
				if (!SUSPEND_REQ)
					susp_reg <= BUS_IDLE ? ST_RUN : ST_WAKE;
			ST_WAKE:
				if (SUSPEND_REQ)
					susp_reg <= ST_SUSP;
				else if (BUS_IDLE)
					susp_reg <= ST_RUN;
			default:
				susp_reg <= ST_RUN;
			endcase
		end
	end

	// transmit aborted by an error frame while draining is sent again on resume
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			drain_err_reg <= 1'b0;
			retx_pending_reg <= 1'b0;
			retx_reg <= 1'b0;
		end
		else
		begin
			retx_reg <= 1'b0;
			if (susp_reg == ST_DRAIN && FRAME_ERROR && TX_ACTIVE)
				drain_err_reg <= 1'b1;
			if (susp_reg == ST_DRAIN && FRAME_END)
			begin
				retx_pending_reg <= drain_err_reg || (FRAME_ERROR && TX_ACTIVE);
				drain_err_reg <= 1'b0;
			end
			if (susp_reg != ST_RUN && susp_reg != ST_DRAIN && !SUSPEND_REQ && BUS_IDLE
				&& retx_pending_reg)
			begin
				retx_reg <= 1'b1;
				retx_pending_reg <= 1'b0;
			end
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign BUS_OFF = bus_off_reg;
	assign TX_DRIVE_EN = drive_reg;
	assign SELF_ACK = ack_reg;
	assign LOOP_STORE_VALID = loop_valid_reg;
	assign LOOP_STORE_INDEX = loop_idx_reg;
	assign LOOP_ID_WRITE = 1'b0;
	assign LOOP_DISCARD = loop_discard_reg;
	assign SOFT_RESET_PULSE = srst_reg;
	assign TX_CANCEL = cancel_reg;
	assign MAILBOX_TX_INHIBIT = inhibit_reg;
	assign SUSPENDED = susp_now;
	assign ERR_CNT_FREEZE = susp_now;
	assign RETRANSMIT = retx_reg;
	assign TIMING = timing_reg;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	busoff_auto_a: assert property ($fell(bus_off_reg) |-> $past(recovered_reg))
		else $error("bus-off left before recovery count");
	busoff_manual_a: assert property ($fell(bus_off_reg) && !$past(mode_reg.auto_recover_enable)
		|-> !$past(mode_reg.config_change_request))
		else $error("bus-off left with change request set");
	loop_nodrive_a: assert property ((mode_reg.self_loopback_mode && !SUSPENDED) [*2]
		|-> !TX_DRIVE_EN && SELF_ACK)
		else $error("drive or ack wrong in loopback");
	loop_noid_a: assert property (LOOP_STORE_VALID |-> !LOOP_ID_WRITE)
		else $error("identifier written on loopback");
	loop_first_a: assert property (TX_FRAME_DONE && mode_reg.self_loopback_mode
		&& RX_CAPABLE == 32'h0000_0000 |=> LOOP_STORE_VALID && LOOP_STORE_INDEX == 5'h00)
		else $error("loopback not stored in first mailbox");
	loop_drop_a: assert property (TX_FRAME_DONE && mode_reg.self_loopback_mode
		&& RX_CAPABLE != 32'h0000_0000 && (RX_CAPABLE & ACCEPT_HIT) == 32'h0000_0000
		|=> LOOP_DISCARD && !LOOP_STORE_VALID)
		else $error("unmatched loopback not dropped");
	srst_readzero_a: assert property (rd && hit_mode |=> !PRDATA[`CMC_B_SRST] && PREADY)
		else $error("soft reset bit read as one");
	srst_pulse_a: assert property (SOFT_RESET_PULSE |=> !SOFT_RESET_PULSE && TX_CANCEL
		&& !mode_reg.data_change_request)
		else $error("soft reset pulse wrong");
	timing_locked_a: assert property (wr && hit_timing && !(PROTECTED_WRITE_UNLOCK
		&& mode_reg.config_change_request) |=> $stable(timing_reg))
		else $error("timing written while locked");
	compat_index_a: assert property (mode_reg.standard_compat_mode |-> !mode_reg.data_update_mailbox_index[4])
		else $error("index top bit set in compat mode");
	inhibit_sel_a: assert property (mode_reg.data_change_request [*2]
		|-> MAILBOX_TX_INHIBIT[$past(mode_reg.data_update_mailbox_index)])
		else $error("changing mailbox not inhibited");

	sequence req_busy_s;
		susp_reg == ST_RUN && SUSPEND_REQ && !BUS_IDLE;
	endsequence
	sequence frame_over_s;
		!FRAME_END [*4] ##1 FRAME_END;
	endsequence
	susp_wait_a: assert property (req_busy_s ##1 frame_over_s |=> SUSPENDED)
		else $error("suspend not entered after frame");
	susp_idle_a: assert property (susp_reg == ST_RUN && SUSPEND_REQ && BUS_IDLE |=> SUSPENDED)
		else $error("suspend not entered on idle");
	resume_idle_a: assert property ($fell(SUSPENDED) |-> $past(BUS_IDLE) && !$past(SUSPEND_REQ))
		else $error("resumed while bus busy");
	susp_freeze_a: assert property (SUSPENDED |-> ERR_CNT_FREEZE ##1 (!TX_DRIVE_EN || !SUSPENDED))
		else $error("suspended node not frozen");
endmodule : cmc_top
`default_nettype wire

// ==== bench/cmc_bus_model.sv ====
// bus-side model: bit ticks, frame boundaries and loopback sources
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_model
(
	input wire logic clk,
	output logic bit_tick,
	output logic bit_rec,
	output logic boff_enter,
	output logic bus_idle,
	output logic frame_end,
	output logic frame_err,
	output logic tx_active,
	output logic tx_done
);
	initial
	begin
		{bit_tick, bit_rec, boff_enter, frame_end, frame_err, tx_active, tx_done} = '0;
		bus_idle = 1'b1;
	end
	task pulse(input int sel, input logic err);
		@(posedge clk);
		case (sel)
			0: boff_enter <= 1'b1;
			1: tx_done <= 1'b1;
			default:
			begin
				frame_end <= 1'b1;
				frame_err <= err;
			end
		endcase
		@(posedge clk);
		{boff_enter, tx_done, frame_end, frame_err} <= '0;
	endtask : pulse
	task ticks(input int n, input logic rx_error_counter);
		repeat (n)
		begin
			@(posedge clk);
			bit_tick <= 1'b1;
			bit_rec <= rx_error_counter;
			@(posedge clk);
			bit_tick <= 1'b0;
			// level between ticks carries nothing, so show the opposite
			bit_rec <= !rx_error_counter;
		end
	endtask : ticks
	task line(input logic idle, input logic tx);
		@(posedge clk);
		bus_idle <= idle;
		tx_active <= tx;
	endtask : line
endmodule : cmc_bus_model
`default_nettype wire

// ==== bench/can_mode_and_bit_timing_control_tb.sv ====
// self-checking bench for the CAN mode control block
`timescale 1ns/1ps
`default_nettype none
module can_mode_and_bit_timing_control_tb;
	logic clk, nrst, psel, penable, pwrite, unlock, susp;
	logic [11:0] paddr;
	logic [31:0] pwdata, rxc, hit, r, h;
	wire [31:0] prdata, inhibit;
	wire [23:0] timing;
	wire [4:0] ls_idx;
	wire pready, pslverr, bus_off, drive_en, self_ack, ls_valid, id_wr, discard;
	wire srst, cancel, suspended, freeze, retx;
	wire tick, rx_error_counter, boff_en, idle, fend, ferr, txa, txd;
	int bad_count, total_checks, seed, srst_n, retx_n, cancel_n, i, k;
	logic [32:0] expq[$];
	logic [32:0] exp_v;
	cmc_top u_cmc_top (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PROTECTED_WRITE_UNLOCK(unlock),
		.BIT_TICK(tick), .BIT_RECESSIVE(rx_error_counter), .BUS_OFF_ENTER(boff_en), .BUS_IDLE(idle),
		.FRAME_END(fend), .FRAME_ERROR(ferr), .TX_ACTIVE(txa), .TX_FRAME_DONE(txd),
		.RX_CAPABLE(rxc), .ACCEPT_HIT(hit), .SUSPEND_REQ(susp), .BUS_OFF(bus_off),
		.TX_DRIVE_EN(drive_en), .SELF_ACK(self_ack), .LOOP_STORE_VALID(ls_valid),
		.LOOP_STORE_INDEX(ls_idx), .LOOP_ID_WRITE(id_wr), .LOOP_DISCARD(discard),
		.SOFT_RESET_PULSE(srst), .TX_CANCEL(cancel), .MAILBOX_TX_INHIBIT(inhibit),
		.SUSPENDED(suspended), .ERR_CNT_FREEZE(freeze), .RETRANSMIT(retx),
		.TIMING(timing));
	cmc_bus_model u_cmc_bus_model (.clk(clk), .bit_tick(tick), .bit_rec(rx_error_counter),
		.boff_enter(boff_en), .bus_idle(idle), .frame_end(fend), .frame_err(ferr),
		.tx_active(txa), .tx_done(txd));
	task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
		total_checks++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask : chk
	task wrap_up;
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			expq.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		while (!pready && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (!pready)
		begin
			chk("pready", 1, 0);
			wrap_up();
		end
	endtask : apb
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (srst)
			srst_n++;
		if (retx)
			retx_n++;
		if (cancel)
			cancel_n++;
		if (pready && psel && !pwrite)
		begin
			exp_v = (expq.size() > 0) ? expq.pop_front() : 33'h1_FFFF_FFFF;
			chk("read", exp_v, {pslverr, prdata});
		end
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		chk("watchdog", 1, 0);
		wrap_up();
	end
	initial
	begin
		{nrst, psel, penable, pwrite, unlock, susp} = '0;
		{paddr, pwdata, rxc, hit} = '0;
		seed = 36;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		apb(0, 12'h000, 0, 33'h0_0000_1000);
		apb(0, 12'h004, 0, 33'h0);
		apb(1, 12'h004, 32'hFFFF_FFFF, 0);
		apb(0, 12'h004, 0, 33'h0);
		unlock <= 1'b1;
		apb(1, 12'h004, 32'hFFFF_FFFF, 0);
		apb(0, 12'h004, 0, 33'h0_00FF_03FF);
		chk("timing out", 24'hFF_03FF, timing);
		apb(0, 12'h008, 0, 33'h1_0000_0000);
		apb(1, 12'h000, 32'h0000_11DF, 0);
		apb(0, 12'h000, 0, 33'h0_0000_11DF);
		chk("inhibit", 32'h8000_0000, inhibit);
		chk("self ack", 1, self_ack);
		chk("drive in loop", 0, drive_en);
		apb(1, 12'h000, 32'h0000_11FF, 0);
		apb(0, 12'h000, 0, 33'h0_0000_10C0);
		chk("soft reset pulses", 1, srst_n);
		chk("cancel", 1, cancel_n);
		apb(0, 12'h004, 0, 33'h0_00FF_03FF);
		for (i = 0; i < 6; i++)
		begin
			r = $random(seed);
			h = $random(seed);
			if (i == 0)
				r = '0;
			if (i == 1)
				h = ~r;
			@(posedge clk);
			rxc <= r;
			hit <= h;
			u_cmc_bus_model.pulse(1, 0);
			@(negedge clk);
			k = 0;
			while (k < 32 && !(r[k] && h[k]))
				k++;
			if (r == 0)
				k = 0;
			chk("store valid", k < 32, ls_valid);
			chk("discard", k == 32, discard);
			if (k < 32)
				chk("store index", k, ls_idx);
			chk("id write", 0, id_wr);
		end
		apb(1, 12'h000, 32'h0000_1080, 0);
		@(negedge clk);
		chk("drive normal", 1, drive_en);
		u_cmc_bus_model.pulse(0, 0);
		u_cmc_bus_model.ticks(5, 1);
		u_cmc_bus_model.ticks(1, 0);
		u_cmc_bus_model.ticks(1407, 1);
		chk("bus off held", 1, bus_off);
		u_cmc_bus_model.ticks(1, 1);
		repeat (3) @(posedge clk);
		chk("bus off auto", 0, bus_off);
		apb(1, 12'h000, 32'h0000_1000, 0);
		u_cmc_bus_model.pulse(0, 0);
		u_cmc_bus_model.ticks(1408, 1);
		repeat (3) @(posedge clk);
		chk("bus off manual", 1, bus_off);
		apb(1, 12'h000, 32'h0000_0000, 0);
		repeat (3) @(posedge clk);
		chk("bus off cleared", 0, bus_off);
		susp <= 1'b1;
		repeat (3) @(posedge clk);
		chk("suspend idle", 1, suspended);
		chk("freeze", 1, freeze);
		chk("drive off", 0, drive_en);
		susp <= 1'b0;
		repeat (3) @(posedge clk);
		chk("resume idle", 0, suspended);
		u_cmc_bus_model.line(0, 1);
		susp <= 1'b1;
		repeat (4) @(posedge clk);
		chk("wait frame", 0, suspended);
		u_cmc_bus_model.pulse(2, 1);
		repeat (2) @(posedge clk);
		chk("suspend after error", 1, suspended);
		susp <= 1'b0;
		repeat (4) @(posedge clk);
		chk("hold until idle", 1, suspended);
		u_cmc_bus_model.line(1, 0);
		repeat (3) @(posedge clk);
		chk("resume", 0, suspended);
		chk("retransmit", 1, retx_n);
		apb(1, 12'h000, 32'h0000_201F, 0);
		apb(0, 12'h000, 0, 33'h0_0000_200F);
		wrap_up();
	end
endmodule : can_mode_and_bit_timing_control_tb
`default_nettype wire
